// ### design/msr_pkg.sv
// constants for the mode and supply control register pair
package msr_pkg;
  // serial frame layout: first byte write flag and address, second byte data
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int FRAME_WR_BIT = 7;
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HW_CTRL0 = 7'h02;
  // mode_supply_control field positions
  localparam int MS_MODE_HI = 7;
  localparam int MS_MODE_LO = 6;
  localparam int MS_SEC_HI = 4;
  localparam int MS_SEC_LO = 3;
  localparam int MS_OVR_BIT = 2;
  localparam int MS_RT_HI = 1;
  localparam int MS_RT_LO = 0;
  // hardware_control_0 field positions
  localparam int HW_SRR_BIT = 6;
  localparam int HW_FO_BIT = 5;
  localparam int HW_CP_BIT = 2;
  localparam int HW_WATCHDOG_FAILURE_COUNT_SELECT_BIT = 0;
  // operating mode encodings
  typedef enum logic [1:0] {
    MSR_MODE_NORMAL = 2'h0,
    MSR_MODE_SLEEP = 2'h1,
    MSR_MODE_STOP = 2'h2,
    MSR_MODE_SOFTRST = 2'h3
  } msr_mode_e;
  // secondary regulator mode encodings
  localparam logic [1:0] SEC_OFF = 2'h0;
  localparam logic [1:0] SEC_NORMAL = 2'h1;
  localparam logic [1:0] SEC_NORMAL_STOP = 2'h2;
  localparam logic [1:0] SEC_ALWAYS = 2'h3;
  // power-on values and the value read at unmapped addresses
  localparam logic [1:0] SEC_POR_DEV = SEC_ALWAYS;
  localparam logic [1:0] SEC_POR = SEC_OFF;
  localparam logic [1:0] RT_POR = 2'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // reset pin pulse on soft reset
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int SOFT_RST_LOW_NS = 1000;
  localparam int SOFT_RST_LOW_CYCLES =
    (SOFT_RST_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
endpackage : msr_pkg

// ### design/msr_regs.sv
// mode, supply and hardware control registers behind the serial link
// Summary of operation
// - mode field 00 normal, 01 sleep, 10 stop; writing 11 runs soft reset
// - a serial write asking stop to sleep is refused
// - stop to normal write ignores bits 4:0, sets serial fail, still goes normal
// - entering restart rewrites mode field to normal
// - restart or overtemperature clears secondary regulator field to off
// - secondary field 00 off, 01 normal, 10 normal+stop, 11 always with exceptions
// - overvoltage always sets its flag; escalates only when bit 2 is one
// - threshold field 00 highest, stepping down to 11
// - a write returns the contents held before the write
// - development mode powers secondary field up as 11; soft reset clears it
// - reserved bits read zero
// - bit 6 zero pulls reset output low on soft reset, one suppresses it
// - bit 5 drives fail output from software when pin configured for it
// - clearing bit 5 leaves failure-driven fail output on until flag cleared
// - restart clears bit 5 and releases fail output unless failure holds it
// - bit 2 of hardware control enables charge pump; lockable
// - bit 0 selects restart after second (0) or first (1) watchdog failure
// - soft reset keeps locked soft-reset config and locked charge pump enable
// - locked bits ignore writes; lock bits themselves kept elsewhere
`timescale 1ns/1ps
`default_nettype none
module msr_regs
  import msr_pkg::*;
#(
  parameter int RST_LOW_CYCLES = SOFT_RST_LOW_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic SPI_CSN_N,
  input wire logic SPI_SCK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_EN,
  input wire logic DEVELOPMENT_MODE,
  input wire logic INIT_ACTIVE,
  input wire logic RESTART_ENTER,
  input wire logic RESTART_ACTIVE,
  input wire logic FAILSAFE_ACTIVE,
  input wire logic OVERTEMP_EVENT,
  input wire logic MAIN_OV_EVENT,
  input wire logic MAIN_OV_FLAG_CLR,
  input wire logic SERIAL_FAIL_CLR,
  input wire logic FAILURE_ACTIVE,
  input wire logic FAIL_PIN_IS_OUTPUT,
  input wire logic CFG_LOCK0,
  input wire logic CFG_LOCK1,
  output logic [1:0] MODE_REQUEST,
  output logic SOFT_RESET_PULSE,
  output logic RESET_OUTPUT_PIN_N,
  output logic [1:0] SECONDARY_REGULATOR_MODE,
  output logic SECONDARY_REGULATOR_ON,
  output logic MAIN_OVERVOLTAGE_FLAG,
  output logic MAIN_OV_ESCALATE,
  output logic [1:0] MAIN_RESET_THRESHOLD,
  output logic SERIAL_FAIL_FLAG,
  output logic FAIL_OUTPUT,
  output logic CHARGE_PUMP_ENABLE,
  output logic WATCHDOG_FAILURE_COUNT_SELECT
);
  localparam int CW = $clog2(RST_LOW_CYCLES + 1);
  // a zero-length pulse hides the pin behaviour; the pin check delay caps it at 300
  if (RST_LOW_CYCLES < 1 || RST_LOW_CYCLES > 300) begin : g_chk
    $error("RST_LOW_CYCLES must lie between 1 and 300");
  end
  logic addr_stb;
  logic frame_stb;
  logic frame_wr;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic [7:0] rd_data;
  logic [7:0] ms_rd;
  logic [7:0] hw_rd;
  msr_mode_e mode_q;
  logic [1:0] sec_q;
  logic ovr_q;
  logic [1:0] rt_q;
  logic srr_q;
  logic fo_q;
  logic cp_q;
  logic watchdog_failure_count_select_q;
  logic ov_flag_q;
  logic spi_fail_q;
  logic soft_pulse_q;
  logic esc_q;
  logic sec_on_q;
  logic fail_out_q;
  logic rst_n_q;
  logic [CW-1:0] rst_cnt_q;
  logic dev_q;
  logic wr_ms;
  logic wr_hw;
  msr_mode_e new_mode;
  logic soft_rst;
  logic stop_to_sleep;
  logic stop_to_normal;
  msr_spi_frame u_frame (
    .clk(CLOCK),
    .srst(SRST),
    .csn_n(SPI_CSN_N),
    .sck(SPI_SCK),
    .sdi(SPI_SDI),
    .sdo(SPI_SDO),
    .sdo_en(SPI_SDO_EN),
    .rd_data(rd_data),
    .addr_stb(addr_stb),
    .frame_stb(frame_stb),
    .frame_wr(frame_wr),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );
  // read images; reserved bits fixed at zero, hardware updates seen live
  assign ms_rd = {mode_q, 1'b0, sec_q, ovr_q, rt_q};
  assign hw_rd = {1'b0, srr_q, fo_q, 2'b00, cp_q, 1'b0, watchdog_failure_count_select_q};
  // read mux feeds the shifter before any write of this frame lands
  always_comb begin
    unique case (frame_addr)
      ADDR_MODE_SUPPLY: rd_data = ms_rd;
      ADDR_HW_CTRL0: rd_data = hw_rd;
      default: rd_data = READ_UNMAPPED;
    endcase
  end
  // write decode; frame bit 7 marks a write
  assign wr_ms = frame_stb && frame_wr && frame_addr == ADDR_MODE_SUPPLY;
  assign wr_hw = frame_stb && frame_wr && frame_addr == ADDR_HW_CTRL0;
  assign new_mode = msr_mode_e'(frame_data[MS_MODE_HI:MS_MODE_LO]);
  assign soft_rst = wr_ms && new_mode == MSR_MODE_SOFTRST;
  assign stop_to_sleep = wr_ms && mode_q == MSR_MODE_STOP && new_mode == MSR_MODE_SLEEP;
  assign stop_to_normal = wr_ms && mode_q == MSR_MODE_STOP && new_mode == MSR_MODE_NORMAL;

  // development strap, caught while reset is held
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dev_q <= DEVELOPMENT_MODE;
    end
  end

  // mode field; restart beats a write landing in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mode_q <= MSR_MODE_NORMAL;
    end else if (RESTART_ENTER) begin
      mode_q <= MSR_MODE_NORMAL;
    end else if (soft_rst) begin
      mode_q <= MSR_MODE_NORMAL;
    end else if (wr_ms && !stop_to_sleep) begin
      mode_q <= new_mode;
    end
  end

  // secondary regulator field: power-on value depends on development strap
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sec_q <= DEVELOPMENT_MODE ? SEC_POR_DEV : SEC_POR;
    end else if (RESTART_ENTER || OVERTEMP_EVENT) begin
      sec_q <= SEC_OFF;
    end else if (soft_rst) begin
      sec_q <= SEC_POR;
    end else if (wr_ms && !stop_to_sleep && !stop_to_normal) begin
      sec_q <= frame_data[MS_SEC_HI:MS_SEC_LO];
    end
  end

  // overvoltage reaction and reset threshold; restart leaves them alone
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      ovr_q <= 1'b0;
      rt_q <= RT_POR;
    end else if (wr_ms && !stop_to_sleep && !stop_to_normal) begin
      ovr_q <= frame_data[MS_OVR_BIT];
      rt_q <= frame_data[MS_RT_HI:MS_RT_LO];
    end
  end

  // serial fail flag: set wins over clear
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      spi_fail_q <= 1'b0;
    end else if (stop_to_normal || stop_to_sleep) begin
      spi_fail_q <= 1'b1;
    end else if (SERIAL_FAIL_CLR) begin
      spi_fail_q <= 1'b0;
    end
  end

  // overvoltage flag always set; escalation only when enabled
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ov_flag_q <= 1'b0;
      esc_q <= 1'b0;
    end else begin
      esc_q <= MAIN_OV_EVENT & ovr_q;
      if (MAIN_OV_EVENT) begin
        ov_flag_q <= 1'b1;
      end else if (MAIN_OV_FLAG_CLR) begin
        ov_flag_q <= 1'b0;
      end
    end
  end

  // soft-reset configuration: locked by the second lock bit
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      srr_q <= 1'b0;
    end else if (soft_rst && !CFG_LOCK1) begin
      srr_q <= 1'b0;
    end else if (wr_hw && !CFG_LOCK1) begin
      srr_q <= frame_data[HW_SRR_BIT];
    end
  end

  // charge pump enable: locked by the first lock bit
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cp_q <= 1'b0;
    end else if (soft_rst && !CFG_LOCK0) begin
      cp_q <= 1'b0;
    end else if (wr_hw && !CFG_LOCK0) begin
      cp_q <= frame_data[HW_CP_BIT];
    end
  end

  // software fail bit and watchdog failure count select
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fo_q <= 1'b0;
      watchdog_failure_count_select_q <= 1'b0;
    end else begin
      if (RESTART_ENTER || soft_rst) begin
        fo_q <= 1'b0;
      end else if (wr_hw) begin
        fo_q <= frame_data[HW_FO_BIT];
      end
      if (soft_rst) begin
        watchdog_failure_count_select_q <= 1'b0;
      end else if (wr_hw) begin
        watchdog_failure_count_select_q <= frame_data[HW_WATCHDOG_FAILURE_COUNT_SELECT_BIT];
      end
    end
  end

  // fail output: failure keeps it on whatever software does
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fail_out_q <= 1'b0;
    end else begin
      fail_out_q <= FAILURE_ACTIVE | (fo_q & FAIL_PIN_IS_OUTPUT);
    end
  end

  // secondary regulator switch from field and device state
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sec_on_q <= 1'b0;
    end else begin
      unique case (sec_q)
        SEC_OFF: sec_on_q <= 1'b0;
        SEC_NORMAL: sec_on_q <= mode_q == MSR_MODE_NORMAL && !INIT_ACTIVE
                                && !RESTART_ACTIVE && !FAILSAFE_ACTIVE;
        SEC_NORMAL_STOP: sec_on_q <= (mode_q == MSR_MODE_NORMAL || mode_q == MSR_MODE_STOP)
                                     && !INIT_ACTIVE && !RESTART_ACTIVE
                                     && !FAILSAFE_ACTIVE;
        SEC_ALWAYS: sec_on_q <= !(INIT_ACTIVE && !dev_q) && !RESTART_ACTIVE
                                && !FAILSAFE_ACTIVE;
      endcase
    end
  end

  // soft reset pulse and reset pin low time; counter only runs when asked
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      soft_pulse_q <= 1'b0;
      rst_cnt_q <= '0;
      rst_n_q <= 1'b1;
    end else begin
      soft_pulse_q <= soft_rst;
      if (soft_rst && !srr_q) begin
        rst_cnt_q <= CW'(RST_LOW_CYCLES);
        rst_n_q <= 1'b0;
      end else if (rst_cnt_q > CW'(1)) begin
        rst_cnt_q <= rst_cnt_q - CW'(1);
      end else begin
        rst_cnt_q <= '0;
        rst_n_q <= 1'b1;
      end
    end
  end

  assign MODE_REQUEST = mode_q;
  assign SOFT_RESET_PULSE = soft_pulse_q;
  assign RESET_OUTPUT_PIN_N = rst_n_q;
  assign SECONDARY_REGULATOR_MODE = sec_q;
  assign SECONDARY_REGULATOR_ON = sec_on_q;
  assign MAIN_OVERVOLTAGE_FLAG = ov_flag_q;
  assign MAIN_OV_ESCALATE = esc_q;
  assign MAIN_RESET_THRESHOLD = rt_q;
  assign SERIAL_FAIL_FLAG = spi_fail_q;
  assign FAIL_OUTPUT = fail_out_q;
  assign CHARGE_PUMP_ENABLE = cp_q;
  assign WATCHDOG_FAILURE_COUNT_SELECT = watchdog_failure_count_select_q;

  property p_softrst_pulse;
    @(posedge CLOCK) disable iff (SRST)
    soft_rst |=> SOFT_RESET_PULSE && MODE_REQUEST == 2'h0;
  endproperty
  a_softrst_pulse: assert property (p_softrst_pulse) else $error("soft reset not seen");
  property p_stop_sleep;
    @(posedge CLOCK) disable iff (SRST)
    stop_to_sleep && !RESTART_ENTER |=> MODE_REQUEST == 2'h2 && $stable(rt_q);
  endproperty
  a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep accepted");
  property p_stop_normal;
    @(posedge CLOCK) disable iff (SRST)
    stop_to_normal && !RESTART_ENTER && !OVERTEMP_EVENT
      |=> MODE_REQUEST == 2'h0 && SERIAL_FAIL_FLAG && $stable(ms_rd[4:0]);
  endproperty
  a_stop_normal: assert property (p_stop_normal) else $error("stop to normal wrong");
  property p_restart;
    @(posedge CLOCK) disable iff (SRST)
    RESTART_ENTER |=> MODE_REQUEST == 2'h0 && sec_q == 2'h0 && !fo_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart values wrong");
  property p_overtemp;
    @(posedge CLOCK) disable iff (SRST)
    OVERTEMP_EVENT |=> SECONDARY_REGULATOR_MODE == 2'h0 ##1 !SECONDARY_REGULATOR_ON;
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("regulator not off");
  property p_ov;
    @(posedge CLOCK) disable iff (SRST)
    MAIN_OV_EVENT |=> MAIN_OVERVOLTAGE_FLAG && (MAIN_OV_ESCALATE == $past(ovr_q));
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage handling wrong");
  property p_rst_pin;
    @(posedge CLOCK) disable iff (SRST)
    soft_rst && !srr_q |=> !RESET_OUTPUT_PIN_N [*1] ##(RST_LOW_CYCLES) RESET_OUTPUT_PIN_N;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin pulse wrong");
  property p_no_rst_pin;
    @(posedge CLOCK) disable iff (SRST)
    soft_rst && srr_q && RESET_OUTPUT_PIN_N |=> RESET_OUTPUT_PIN_N;
  endproperty
  a_no_rst_pin: assert property (p_no_rst_pin) else $error("reset pin pulsed");
  property p_fail_out;
    @(posedge CLOCK) disable iff (SRST)
    FAILURE_ACTIVE |=> FAIL_OUTPUT;
  endproperty
  a_fail_out: assert property (p_fail_out) else $error("fail output released");
  property p_lock0;
    @(posedge CLOCK) disable iff (SRST)
    CFG_LOCK0 && (wr_hw || soft_rst) |=> $stable(CHARGE_PUMP_ENABLE);
  endproperty
  a_lock0: assert property (p_lock0) else $error("locked charge pump changed");
  property p_read_old;
    @(posedge CLOCK) disable iff (SRST)
    addr_stb && frame_addr == ADDR_MODE_SUPPLY |=> u_frame.shout_q == $past(ms_rd);
  endproperty
  a_read_old: assert property (p_read_old) else $error("read image not old value");
endmodule : msr_regs
`default_nettype wire

// ### design/msr_spi_frame.sv
// byte-wise serial frame shifter: address byte in, data byte in and out
`timescale 1ns/1ps
`default_nettype none
module msr_spi_frame
  import msr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic csn_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_en,
  input wire logic [7:0] rd_data,
  output logic addr_stb,
  output logic frame_stb,
  output logic frame_wr,
  output logic [6:0] frame_addr,
  output logic [7:0] frame_data
);
  logic sck_prev_q;
  logic [4:0] cnt_q;
  logic [7:0] shin_q;
  logic [7:0] shout_q;
  logic addr_stb_q;
  logic frame_stb_q;
  logic wr_q;
  logic [6:0] addr_q;
  logic [7:0] data_q;
  logic rise;
  logic fall;

  // inputs are synchronous, so plain edge detection on the sampled clock
  assign rise = sck & ~sck_prev_q & ~csn_n;
  assign fall = ~sck & sck_prev_q & ~csn_n;

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck;
    end
  end

  // bit counter and input shifter; bits beyond one frame are ignored
  always_ff @(posedge clk) begin
    if (srst || csn_n) begin
      cnt_q <= 5'h00;
      shin_q <= 8'h00;
    end else if (rise && cnt_q < 5'(FRAME_BITS)) begin
      cnt_q <= cnt_q + 5'h01;
      shin_q <= {shin_q[6:0], sdi};
    end
  end

  // byte completion strobes and captured frame fields
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_stb_q <= 1'b0;
      frame_stb_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 7'h00;
      data_q <= 8'h00;
    end else begin
      addr_stb_q <= 1'b0;
      frame_stb_q <= 1'b0;
      if (rise && cnt_q == 5'(BYTE_BITS - 1)) begin
        addr_stb_q <= 1'b1;
        wr_q <= shin_q[6];
        addr_q <= {shin_q[5:0], sdi};
      end
      if (rise && cnt_q == 5'(FRAME_BITS - 1)) begin
        frame_stb_q <= 1'b1;
        data_q <= {shin_q[6:0], sdi};
      end
    end
  end

  // output shifter: loads the old register contents once the address is known;
  // the fall right after the load must not shift, or bit 7 is gone before the host samples
  always_ff @(posedge clk) begin
    if (srst || csn_n) begin
      shout_q <= 8'h00;
    end else if (addr_stb_q) begin
      shout_q <= rd_data;
    end else if (fall && cnt_q > 5'(BYTE_BITS)) begin
      shout_q <= {shout_q[6:0], 1'b0};
    end
  end

  assign sdo = shout_q[7];
  assign sdo_en = ~csn_n;
  assign addr_stb = addr_stb_q;
  assign frame_stb = frame_stb_q;
  assign frame_wr = wr_q;
  assign frame_addr = addr_q;
  assign frame_data = data_q;
endmodule : msr_spi_frame
`default_nettype wire

// ### tb/msr_host.sv
// host-side serial master model running byte frames on the register link
`timescale 1ns/1ps
`default_nettype none
module msr_host (
  input wire logic clk,
  input wire logic sdo,
  output logic csn_n,
  output logic sck,
  output logic sdi
);
  // idle link: deselected, clock parked low
  initial begin
    csn_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // one frame of two clocks per phase; answer bits taken late in the high phase
  task automatic xfer(input logic wr, input logic [6:0] adr, input logic [7:0] dat,
                      output logic [7:0] rx);
    logic [15:0] frm;
    frm = {wr, adr, dat};
    rx = 8'h00;
    @(posedge clk);
    csn_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= frm[i];
      repeat (2) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      if (i < 8) rx[i] = sdo;
      sck <= 1'b0;
    end
    // keep select low until the write has landed
    repeat (4) @(posedge clk);
    csn_n <= 1'b1;
    sdi <= ~frm[0];
    repeat (2) @(posedge clk);
  endtask : xfer
endmodule : msr_host
`default_nettype wire

// ### tb/msr_regs_tb.sv
// self-checking bench for the mode, supply and hardware control registers
`timescale 1ns/1ps
`default_nettype none
module msr_regs_tb
  import msr_pkg::*;
;
  localparam int LOW_CYC = 3;
  logic clock, srst, dev, fs, fail, fpin, lock0, lock1, init, ract;
  logic [4:0] evs;
  wire logic rst_ent, ot, ov, ov_clr, sf_clr, csn_n, sck, sdi;
  logic sdo, sdo_en, sr_pulse, rst_n, sec_on, ov_flag, ov_esc, sf_flag, fo, cp, wdc;
  logic [1:0] mode, sec, thr;
  logic [7:0] rd;
  int bad_count, cmp_count, low_cnt, sr_cnt, esc_cnt;
  assign {rst_ent, ot, ov, ov_clr, sf_clr} = evs;

  msr_regs #(.RST_LOW_CYCLES(LOW_CYC)) dut (
    .CLOCK(clock), .SRST(srst), .SPI_CSN_N(csn_n), .SPI_SCK(sck), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_EN(sdo_en), .DEVELOPMENT_MODE(dev), .INIT_ACTIVE(init),
    .RESTART_ENTER(rst_ent), .RESTART_ACTIVE(ract), .FAILSAFE_ACTIVE(fs),
    .OVERTEMP_EVENT(ot), .MAIN_OV_EVENT(ov), .MAIN_OV_FLAG_CLR(ov_clr),
    .SERIAL_FAIL_CLR(sf_clr), .FAILURE_ACTIVE(fail), .FAIL_PIN_IS_OUTPUT(fpin),
    .CFG_LOCK0(lock0), .CFG_LOCK1(lock1), .MODE_REQUEST(mode),
    .SOFT_RESET_PULSE(sr_pulse), .RESET_OUTPUT_PIN_N(rst_n),
    .SECONDARY_REGULATOR_MODE(sec), .SECONDARY_REGULATOR_ON(sec_on),
    .MAIN_OVERVOLTAGE_FLAG(ov_flag), .MAIN_OV_ESCALATE(ov_esc),
    .MAIN_RESET_THRESHOLD(thr), .SERIAL_FAIL_FLAG(sf_flag), .FAIL_OUTPUT(fo),
    .CHARGE_PUMP_ENABLE(cp), .WATCHDOG_FAILURE_COUNT_SELECT(wdc)
  );
  msr_host host (.clk(clock), .sdo(sdo), .csn_n(csn_n), .sck(sck), .sdi(sdi));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // short pulses are counted here so none is missed while a frame runs
  always @(posedge clock) begin
    if (rst_n === 1'b0) low_cnt <= low_cnt + 1;
    if (sr_pulse === 1'b1) sr_cnt <= sr_cnt + 1;
    if (ov_esc === 1'b1) esc_cnt <= esc_cnt + 1;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_pin
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  // one-cycle event pulse on bit b of the event vector
  task automatic pulse(input int b);
    @(posedge clock);
    evs[b] <= 1'b1;
    @(posedge clock);
    evs[b] <= 1'b0;
    tick(2);
  endtask : pulse
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd);
    tick(1);
  endtask : wr
  task automatic rdr(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, rd);
    chk_val("read", e, rd);
  endtask : rdr

  // a hang is cut short here and counted as a mismatch
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    {dev, fs, fail, fpin, lock0, lock1, init, ract} = 8'h00;
    evs = 5'h00;
    {bad_count, cmp_count, low_cnt, sr_cnt, esc_cnt} = {5{32'sd0}};
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    chk_pin("sdo_en", 2'b00, {1'b0, sdo_en});
    rdr(ADDR_MODE_SUPPLY, 8'h00);
    rdr(ADDR_HW_CTRL0, 8'h00);
    rdr(7'h05, READ_UNMAPPED);
    wr(ADDR_MODE_SUPPLY, 8'h3F);
    chk_val("prior", 8'h00, rd);
    rdr(ADDR_MODE_SUPPLY, 8'h1F);
    // every threshold and every secondary regulator code
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_MODE_SUPPLY, 8'(8'h18 | n));
      chk_pin("thr", 2'(n), thr);
    end
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_MODE_SUPPLY, 8'(n << 3));
      chk_pin("sec", 2'(n), sec);
      chk_pin("sec_on", {1'b0, n != 0}, {1'b0, sec_on});
    end
    @(posedge clock);
    fs <= 1'b1;
    tick(3);
    chk_pin("sec_on", 2'b00, {1'b0, sec_on});
    // init without the development strap, then restart, each hold the regulator off
    @(posedge clock) {fs, init} <= 2'b01;
    tick(3);
    chk_pin("sec_on", 2'b00, {1'b0, sec_on});
    @(posedge clock) {init, ract} <= 2'b01;
    tick(3);
    chk_pin("sec_on", 2'b00, {1'b0, sec_on});
    @(posedge clock) ract <= 1'b0;
    // overvoltage without and with escalation
    pulse(2);
    chk_pin("ov", 2'b01, {1'b0, ov_flag});
    chk_val("esc", 8'h00, 8'(esc_cnt));
    pulse(1);
    chk_pin("ov", 2'b00, {1'b0, ov_flag});
    wr(ADDR_MODE_SUPPLY, 8'h1C);
    pulse(2);
    chk_val("esc", 8'h01, 8'(esc_cnt));
    chk_pin("ov", 2'b01, {1'b0, ov_flag});
    // mode codes, refused stop to sleep, stop to normal with field bits ignored
    wr(ADDR_MODE_SUPPLY, 8'h5C);
    chk_pin("mode", MSR_MODE_SLEEP, mode);
    wr(ADDR_MODE_SUPPLY, 8'h1C);
    chk_pin("mode", MSR_MODE_NORMAL, mode);
    wr(ADDR_MODE_SUPPLY, 8'h9C);
    chk_pin("mode", MSR_MODE_STOP, mode);
    wr(ADDR_MODE_SUPPLY, 8'h5C);
    chk_val("prior", 8'h9C, rd);
    chk_pin("mode", MSR_MODE_STOP, mode);
    chk_pin("sfail", 2'b01, {1'b0, sf_flag});
    pulse(0);
    chk_pin("sfail", 2'b00, {1'b0, sf_flag});
    wr(ADDR_MODE_SUPPLY, 8'h03);
    chk_pin("mode", MSR_MODE_NORMAL, mode);
    chk_pin("sfail", 2'b01, {1'b0, sf_flag});
    rdr(ADDR_MODE_SUPPLY, 8'h1C);
    pulse(3);
    rdr(ADDR_MODE_SUPPLY, 8'h04);
    // restart clears mode, secondary field and software fail bit
    wr(ADDR_MODE_SUPPLY, 8'h9C);
    @(posedge clock);
    fpin <= 1'b1;
    wr(ADDR_HW_CTRL0, 8'hFF);
    rdr(ADDR_HW_CTRL0, 8'h65);
    chk_pin("cp_wdc", 2'b11, {cp, wdc});
    chk_pin("fo", 2'b01, {1'b0, fo});
    pulse(4);
    rdr(ADDR_MODE_SUPPLY, 8'h04);
    rdr(ADDR_HW_CTRL0, 8'h45);
    chk_pin("fo", 2'b00, {1'b0, fo});
    // failure-held fail output survives clearing the software bit
    wr(ADDR_HW_CTRL0, 8'h65);
    @(posedge clock) fail <= 1'b1;
    wr(ADDR_HW_CTRL0, 8'h45);
    chk_pin("fo", 2'b01, {1'b0, fo});
    @(posedge clock) fail <= 1'b0;
    wr(ADDR_HW_CTRL0, 8'h65);
    @(posedge clock) fpin <= 1'b0;
    tick(3);
    chk_pin("fo", 2'b00, {1'b0, fo});
    // locked charge pump and soft reset under both locks
    @(posedge clock) lock0 <= 1'b1;
    wr(ADDR_HW_CTRL0, 8'h41);
    rdr(ADDR_HW_CTRL0, 8'h45);
    lock1 <= 1'b1;
    {low_cnt, sr_cnt} = {2{32'sd0}};
    wr(ADDR_MODE_SUPPLY, 8'hC0);
    tick(LOW_CYC + 2);
    chk_val("low", 8'h00, 8'(low_cnt));
    chk_val("srp", 8'h01, 8'(sr_cnt));
    rdr(ADDR_HW_CTRL0, 8'h44);
    rdr(ADDR_MODE_SUPPLY, 8'h00);
    lock0 <= 1'b0;
    lock1 <= 1'b0;
    wr(ADDR_HW_CTRL0, 8'h00);
    chk_pin("cp", 2'b00, {1'b0, cp});
    {low_cnt, sr_cnt} = {2{32'sd0}};
    wr(ADDR_MODE_SUPPLY, 8'hC0);
    tick(LOW_CYC + 2);
    chk_val("low", 8'(LOW_CYC), 8'(low_cnt));
    chk_val("srp", 8'h01, 8'(sr_cnt));
    // development strap powers the secondary regulator up
    @(posedge clock);
    dev <= 1'b1;
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    // with the strap the always-on code keeps the regulator on during init
    @(posedge clock) init <= 1'b1;
    tick(3);
    chk_pin("sec_on", 2'b01, {1'b0, sec_on});
    @(posedge clock) init <= 1'b0;
    rdr(ADDR_MODE_SUPPLY, 8'h18);
    wr(ADDR_MODE_SUPPLY, 8'hC0);
    rdr(ADDR_MODE_SUPPLY, 8'h00);
    print_verdict();
  end
endmodule : msr_regs_tb
`default_nettype wire
